// *** rtl/uart_tx_dma_channel_control.sv ***
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RQ1) software always writes continuous mode as one
// (RQ2) continuous mode alternates buffers without processor help
// (RQ3) channel toggles buffer select; manager follows it
// (RQ4) short buffer: send it, terminate, interrupt
// (RQ5) timer expiry terminates transfer and interrupts
// (RQ6) interrupt on run bit falling when allowed
// (RQ7) irq disallowed: short buffer keeps channel running
// (RQ8) writing run one starts the transfer
// (RQ9) hardware clears run on completion or error
// (RQ10) halt on zero byte count or timeout
// (RQ11) on halt write back count, clear nak; this block writes back the count only and has no nak
// (RQ12) partial flag set by hardware, cleared by software
// (RQ13) write one clears flag, zero no effect
// (RQ14) upper seven status bits read zero
// (RQ15) buffer select zero is x, one is y
// (RQ16) direction bit reads one, ignores writes
// (RQ17) three-bit pointer picks descriptor set
// (RQ18) timeout pulse ignored while halted
module uart_tx_dma_channel_control (
   input  wire logic                                 clk_i,
   input  wire logic                                 srst_i,
   // apb slave
   input  wire logic                                 psel_i,
   input  wire logic                                 penable_i,
   input  wire logic                                 pwrite_i,
   input  wire logic [uart_tx_dma_pkg::ADDR_W-1:0]   paddr_i,
   input  wire logic [uart_tx_dma_pkg::DATA_W-1:0]   pwdata_i,
   input  wire logic [3:0]                           pstrb_i,
   output logic      [uart_tx_dma_pkg::DATA_W-1:0]   prdata_o,
   output logic                                      pready_o,
   output logic                                      pslverr_o,
   // buffer manager and descriptors
   output logic      [uart_tx_dma_pkg::PTR_W-1:0]    edb_ptr_o,
   output logic                                      buffer_select_o,
   output logic                                      buf_req_o,
   input  wire logic                                 buf_valid_i,
   input  wire logic [uart_tx_dma_pkg::BCNT_W-1:0]   buf_count_i,
   input  wire logic [uart_tx_dma_pkg::BCNT_W-1:0]   buf_size_i,
   output logic                                      buf_done_o,
   output logic                                      wb_valid_o,
   output logic      [uart_tx_dma_pkg::BCNT_W-1:0]   wb_count_o,
   // shared ram read port
   output logic                                      mem_rd_o,
   output logic      [uart_tx_dma_pkg::BCNT_W-1:0]   mem_addr_o,
   input  wire logic [7:0]                           mem_data_i,
   // serial transmitter
   output logic                                      tx_valid_o,
   output logic      [7:0]                           tx_data_o,
   input  wire logic                                 tx_ready_i,
   // timer and processor
   input  wire logic                                 timeout_i,
   output logic                                      irq_o
);

   // ======================================================================
   // declarations
   uart_tx_dma_pkg::chan_state_t         state_reg;
   uart_tx_dma_pkg::chan_state_t         state_next;
   logic [uart_tx_dma_pkg::PTR_W-1:0]    ptr_reg;
   logic                                 sel_reg;
   logic                                 cont_reg;
   logic                                 irqen_reg;
   logic                                 run_reg;
   logic                                 run_d_reg;
   logic                                 part_reg;
   logic                                 short_reg;
   logic                                 halt_ev;
   logic                                 toggle_ev;
   logic                                 part_ev;
   logic                                 mv_start;
   logic                                 mv_abort;
   logic                                 mv_done;
   logic [uart_tx_dma_pkg::BCNT_W-1:0]   mv_left;
   logic [uart_tx_dma_pkg::BCNT_W-1:0]   halt_count;
   logic                                 acc;
   logic                                 wr_def;
   logic                                 wr_stat;
   logic [7:0]                           def_view;
   logic [7:0]                           stat_view;

   // ======================================================================
   // address decode, shared by read and write paths
   function automatic logic hit(input logic [uart_tx_dma_pkg::ADDR_W-1:0] a, input logic [15:0] idx);
      return a == {idx, 2'b00};
   endfunction

   assign acc     = psel_i & penable_i & pready_o;
   assign wr_def  = acc & pwrite_i & pstrb_i[0] & hit(paddr_i, uart_tx_dma_pkg::DEF_IDX);
   assign wr_stat = acc & pwrite_i & pstrb_i[0] & hit(paddr_i, uart_tx_dma_pkg::STAT_IDX);

   always_comb begin
      def_view                                  = 8'h00;
      def_view[uart_tx_dma_pkg::DEF_PTR_LSB +: uart_tx_dma_pkg::PTR_W] = ptr_reg;
      def_view[uart_tx_dma_pkg::DEF_DIR_BIT]    = 1'b1;        // [RQ16]
      def_view[uart_tx_dma_pkg::DEF_SEL_BIT]    = sel_reg;
      def_view[uart_tx_dma_pkg::DEF_CONT_BIT]   = cont_reg;
      def_view[uart_tx_dma_pkg::DEF_IRQ_BIT]    = irqen_reg;
      def_view[uart_tx_dma_pkg::DEF_RUN_BIT]    = run_reg;
      stat_view                                 = 8'h00;       // [RQ14]
      stat_view[uart_tx_dma_pkg::STAT_PART_BIT] = part_reg;
   end

   // ======================================================================
   // apb: zero wait states, answer registered during the setup cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= uart_tx_dma_pkg::RDATA_ZERO;
      end else if (psel_i && !penable_i && !pready_o) begin
         pready_o  <= 1'b1;
         pslverr_o <= !hit(paddr_i, uart_tx_dma_pkg::DEF_IDX) && !hit(paddr_i, uart_tx_dma_pkg::STAT_IDX);
         if (hit(paddr_i, uart_tx_dma_pkg::DEF_IDX)) begin
            prdata_o <= {24'h000000, def_view};
         end else if (hit(paddr_i, uart_tx_dma_pkg::STAT_IDX)) begin
            prdata_o <= {24'h000000, stat_view};
         end else begin
            prdata_o <= uart_tx_dma_pkg::RDATA_ZERO;
         end
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // ======================================================================
   // channel definition register
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ptr_reg   <= uart_tx_dma_pkg::PTR_RST;
         cont_reg  <= 1'b0;
         irqen_reg <= 1'b0;
      end else if (wr_def) begin
         ptr_reg   <= pwdata_i[uart_tx_dma_pkg::DEF_PTR_LSB +: uart_tx_dma_pkg::PTR_W]; // [RQ17]
         cont_reg  <= pwdata_i[uart_tx_dma_pkg::DEF_CONT_BIT];                          // [RQ1]
         irqen_reg <= pwdata_i[uart_tx_dma_pkg::DEF_IRQ_BIT];
      end
   end

   // a processor write wins over a hardware clear in the same cycle, so a
   // restart written at the moment of a halt is not lost
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         run_reg <= 1'b0;
      end else if (wr_def) begin
         run_reg <= pwdata_i[uart_tx_dma_pkg::DEF_RUN_BIT];   // [RQ8]
      end else if (halt_ev) begin
         run_reg <= 1'b0;                                     // [RQ9]
      end
   end

   // the hardware toggle wins: the manager already follows the new buffer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sel_reg <= 1'b0;
      end else if (toggle_ev) begin
         sel_reg <= ~sel_reg;                                 // [RQ3] [RQ15]
      end else if (wr_def) begin
         sel_reg <= pwdata_i[uart_tx_dma_pkg::DEF_SEL_BIT];
      end
   end

   // ======================================================================
   // status register: partial flag, set wins over clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         part_reg <= 1'b0;
      end else if (part_ev) begin
         part_reg <= 1'b1;                                    // [RQ12]
      end else if (wr_stat && pwdata_i[uart_tx_dma_pkg::STAT_PART_BIT]) begin
         part_reg <= 1'b0;                                    // [RQ13]
      end
   end

   // ======================================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      halt_ev    = 1'b0;
      toggle_ev  = 1'b0;
      part_ev    = 1'b0;
      mv_start   = 1'b0;
      mv_abort   = 1'b0;
      halt_count = uart_tx_dma_pkg::BCNT_ZERO;
      unique case (state_reg)
         uart_tx_dma_pkg::ST_IDLE: begin
            if (run_reg) begin
               state_next = uart_tx_dma_pkg::ST_LOAD;         // [RQ8]
            end
         end
         uart_tx_dma_pkg::ST_LOAD: begin
            if (!run_reg) begin
               state_next = uart_tx_dma_pkg::ST_IDLE;
            end else if (timeout_i) begin
               halt_ev    = 1'b1;                             // [RQ5] [RQ18]
               state_next = uart_tx_dma_pkg::ST_IDLE;
            end else if (buf_valid_i) begin
               if (buf_count_i == uart_tx_dma_pkg::BCNT_ZERO) begin
                  halt_ev    = 1'b1;                          // [RQ10]
                  state_next = uart_tx_dma_pkg::ST_IDLE;
               end else begin
                  mv_start   = 1'b1;
                  state_next = uart_tx_dma_pkg::ST_MOVE;
               end
            end
         end
         uart_tx_dma_pkg::ST_MOVE: begin
            if (!run_reg) begin
               mv_abort   = 1'b1;
               state_next = uart_tx_dma_pkg::ST_IDLE;
            end else if (timeout_i) begin
               mv_abort   = 1'b1;
               halt_ev    = 1'b1;                             // [RQ5] [RQ10]
               halt_count = mv_left;
               state_next = uart_tx_dma_pkg::ST_IDLE;
            end else if (mv_done) begin
               toggle_ev = 1'b1;                              // [RQ3]
               if (short_reg) begin
                  part_ev = 1'b1;                             // [RQ12]
               end
               if (short_reg && irqen_reg) begin
                  halt_ev    = 1'b1;                          // [RQ4]
                  state_next = uart_tx_dma_pkg::ST_IDLE;
               end else if (!short_reg && !cont_reg) begin
                  halt_ev    = 1'b1;
                  state_next = uart_tx_dma_pkg::ST_IDLE;
               end else begin
                  state_next = uart_tx_dma_pkg::ST_LOAD;      // [RQ2] [RQ7]
               end
            end
         end
         default: begin
            state_next = uart_tx_dma_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg <= uart_tx_dma_pkg::ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // short means fewer bytes than the descriptor's buffer size
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         short_reg <= 1'b0;
      end else if (mv_start) begin
         short_reg <= buf_count_i < buf_size_i;               // [RQ4]
      end
   end

   // ======================================================================
   // manager handshake, write-back and interrupt
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         buf_req_o  <= 1'b0;
         buf_done_o <= 1'b0;
         wb_valid_o <= 1'b0;
         wb_count_o <= uart_tx_dma_pkg::BCNT_ZERO;
      end else begin
         buf_req_o  <= state_next == uart_tx_dma_pkg::ST_LOAD && !mv_start;
         buf_done_o <= toggle_ev;
         wb_valid_o <= halt_ev;                               // [RQ11]
         if (halt_ev) begin
            wb_count_o <= halt_count;                         // [RQ11]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         edb_ptr_o       <= uart_tx_dma_pkg::PTR_RST;
         buffer_select_o <= 1'b0;
      end else begin
         edb_ptr_o       <= ptr_reg;                          // [RQ17]
         buffer_select_o <= sel_reg;                          // [RQ3]
      end
   end

   // the interrupt follows the run bit falling for any cause, software too
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         run_d_reg <= 1'b0;
         irq_o     <= 1'b0;
      end else begin
         run_d_reg <= run_reg;
         irq_o     <= run_d_reg & ~run_reg & irqen_reg;       // [RQ6]
      end
   end

   // ======================================================================
   // data path
   tx_byte_mover u_mover (
      .clk_i      (clk_i),
      .srst_i     (srst_i),
      .start_i    (mv_start),
      .abort_i    (mv_abort),
      .count_i    (buf_count_i),
      .mem_rd_o   (mem_rd_o),
      .mem_addr_o (mem_addr_o),
      .mem_data_i (mem_data_i),
      .tx_valid_o (tx_valid_o),
      .tx_data_o  (tx_data_o),
      .tx_ready_i (tx_ready_i),
      .left_o     (mv_left),
      .done_o     (mv_done)
   );

endmodule // uart_tx_dma_channel_control
`default_nettype wire

// *** inc/uart_tx_dma_pkg.sv ***
`default_nettype none
package uart_tx_dma_pkg;

   // ======================================================================
   // bus and data widths
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int BCNT_W = 7;
   localparam int PTR_W  = 3;

   // ======================================================================
   // register indices; byte address is four times the index
   localparam logic [15:0] DEF_IDX  = 16'hFFE0;
   localparam logic [15:0] STAT_IDX = 16'hFFE1;

   // ======================================================================
   // channel definition fields
   localparam int DEF_PTR_LSB  = 0;
   localparam int DEF_DIR_BIT  = 3;
   localparam int DEF_SEL_BIT  = 4;
   localparam int DEF_CONT_BIT = 5;
   localparam int DEF_IRQ_BIT  = 6;
   localparam int DEF_RUN_BIT  = 7;

   // ======================================================================
   // channel status fields
   localparam int STAT_PART_BIT = 0;

   // ======================================================================
   // reset values and the count step
   localparam logic [PTR_W-1:0]  PTR_RST  = 3'h0;
   localparam logic [BCNT_W-1:0] BCNT_ZERO = 7'h00;
   localparam logic [BCNT_W-1:0] BCNT_ONE  = 7'h01;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

   // ======================================================================
   // channel sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LOAD = 2'b01,
      ST_MOVE = 2'b10
   } chan_state_t;

endpackage
`default_nettype wire

// *** rtl/tx_byte_mover.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// byte mover: reads one buffer from shared ram and feeds the transmitter
module tx_byte_mover (
   input  wire logic                               clk_i,
   input  wire logic                               srst_i,
   input  wire logic                               start_i,
   input  wire logic                               abort_i,
   input  wire logic [uart_tx_dma_pkg::BCNT_W-1:0] count_i,
   output logic                                    mem_rd_o,
   output logic      [uart_tx_dma_pkg::BCNT_W-1:0] mem_addr_o,
   input  wire logic [7:0]                         mem_data_i,
   output logic                                    tx_valid_o,
   output logic      [7:0]                         tx_data_o,
   input  wire logic                               tx_ready_i,
   output logic      [uart_tx_dma_pkg::BCNT_W-1:0] left_o,
   output logic                                    done_o
);

   logic [uart_tx_dma_pkg::BCNT_W-1:0] issue_reg;
   logic                               busy_reg;
   logic                               pend_reg;
   logic                               take;

   assign take = tx_valid_o & tx_ready_i;

   // ======================================================================
   // read side: one byte in flight at most, memory answers next cycle
   always_ff @(posedge clk_i) begin
      if (srst_i || abort_i) begin
         busy_reg   <= 1'b0;
         pend_reg   <= 1'b0;
         mem_rd_o   <= 1'b0;
         issue_reg  <= uart_tx_dma_pkg::BCNT_ZERO;
         mem_addr_o <= uart_tx_dma_pkg::BCNT_ZERO;
      end else if (start_i) begin
         busy_reg   <= 1'b1;
         pend_reg   <= 1'b0;
         mem_rd_o   <= 1'b0;
         issue_reg  <= count_i;
         mem_addr_o <= uart_tx_dma_pkg::BCNT_ZERO;
      end else begin
         mem_rd_o <= 1'b0;
         if (busy_reg && !pend_reg && !tx_valid_o && !mem_rd_o && issue_reg != uart_tx_dma_pkg::BCNT_ZERO) begin
            mem_rd_o  <= 1'b1;
            pend_reg  <= 1'b1;
            issue_reg <= issue_reg - uart_tx_dma_pkg::BCNT_ONE;
         end else if (pend_reg && !mem_rd_o) begin
            pend_reg   <= 1'b0;
            mem_addr_o <= mem_addr_o + uart_tx_dma_pkg::BCNT_ONE;
         end
         if (done_o) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // ======================================================================
   // transmit side: the byte is held until the transmitter takes it
   always_ff @(posedge clk_i) begin
      if (srst_i || abort_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o  <= 8'h00;
      end else if (pend_reg && !mem_rd_o) begin
         tx_valid_o <= 1'b1;
         tx_data_o  <= mem_data_i;
      end else if (take) begin
         tx_valid_o <= 1'b0;
      end
   end

   // ======================================================================
   // remaining count falls only on delivery, so an abort reports bytes not sent
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         left_o <= uart_tx_dma_pkg::BCNT_ZERO;
         done_o <= 1'b0;
      end else if (start_i) begin
         left_o <= count_i;
         done_o <= 1'b0;
      end else begin
         if (take) begin
            left_o <= left_o - uart_tx_dma_pkg::BCNT_ONE;
         end
         done_o <= busy_reg && !done_o && !abort_i && take && left_o == uart_tx_dma_pkg::BCNT_ONE;
      end
   end

endmodule // tx_byte_mover
`default_nettype wire

// *** sim/uart_tx_dma_channel_control_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======
// port checker for the transmit channel
module uart_tx_dma_channel_control_monitor (
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic        pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic        irq_o,
   input wire logic        buf_done_o,
   input wire logic        buffer_select_o,
   input wire logic        wb_valid_o,
   input wire logic [6:0]  wb_count_o,
   input wire logic        tx_valid_o,
   input wire logic        tx_ready_i,
   input wire logic [7:0]  tx_data_o,
   input wire logic        mem_rd_o,
   input wire logic        buf_req_o,
   input wire logic        buf_valid_i,
   input wire logic [6:0]  buf_count_i,
   input wire logic        timeout_i
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // a timeout aborts the byte, so stalls near one are exempt
   sequence s_stall;
      tx_valid_o && !tx_ready_i && !timeout_i && !$past(timeout_i);
   endsequence
   sequence s_zero_take;
      buf_req_o && buf_valid_i && buf_count_i == 7'h00;
   endsequence
   sequence s_zero_wb;
      ##[1:2] (wb_valid_o && wb_count_o == 7'h00);
   endsequence
   property p_rd_hi;
      pready_o |-> prdata_o[31:8] == 24'h00_0000;
   endproperty
   property p_irq_pulse;
      irq_o |=> !irq_o;
   endproperty
   property p_wb_pulse;
      wb_valid_o |=> !wb_valid_o;
   endproperty
   property p_sel_toggle;
      buf_done_o |-> ##1 (buffer_select_o != $past(buffer_select_o, 2));
   endproperty
   property p_tx_hold;
      s_stall |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   property p_tx_src;
      $rose(tx_valid_o) |-> $past(mem_rd_o, 2);
   endproperty
   property p_zero_halt;
      s_zero_take |-> s_zero_wb;
   endproperty
   property p_timeout_halt;
      timeout_i && tx_valid_o |-> ##[1:3] wb_valid_o;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("prdata high bits");
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
   a_wb_pulse: assert property (p_wb_pulse) else $error("wb too long");
   a_sel_toggle: assert property (p_sel_toggle) else $error("no select toggle");
   a_tx_hold: assert property (p_tx_hold) else $error("byte dropped");
   a_tx_src: assert property (p_tx_src) else $error("byte without read");
   a_zero_halt: assert property (p_zero_halt) else $error("no empty halt");
   a_timeout_halt: assert property (p_timeout_halt) else $error("no timeout halt");
endmodule // uart_tx_dma_channel_control_monitor

bind uart_tx_dma_channel_control uart_tx_dma_channel_control_monitor u_mon (
   .clk_i, .srst_i, .pready_o, .prdata_o, .irq_o, .buf_done_o, .buffer_select_o, .wb_valid_o,
   .wb_count_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .mem_rd_o, .buf_req_o, .buf_valid_i,
   .buf_count_i, .timeout_i
);
`default_nettype wire

// *** sim/tx_far_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ======
// buffer manager and shared ram stand-in
module tx_far_side_model (
   input  wire logic       clk_i,
   input  wire logic       srst_i,
   input  wire logic       buf_req_i,
   input  wire logic       buffer_select_i,
   input  wire logic       mem_rd_i,
   input  wire logic [6:0] mem_addr_i,
   input  wire logic       avail_i,
   input  wire logic [2:0] delay_i,
   input  wire logic [6:0] cnt_i,
   input  wire logic [6:0] size_i,
   input  wire logic [7:0] salt_i,
   output logic            buf_valid_o,
   output logic      [6:0] buf_count_o,
   output logic      [6:0] buf_size_o,
   output logic      [7:0] mem_data_o
);
   logic [2:0] wait_reg;
   // one-cycle offer after a random wait
   always_ff @(posedge clk_i) begin
      if (srst_i || !buf_req_i || buf_valid_o) begin
         wait_reg    <= 3'h0;
         buf_valid_o <= 1'b0;
      end else if (avail_i && wait_reg >= delay_i) begin
         buf_valid_o <= 1'b1;
      end else begin
         wait_reg <= wait_reg + 3'h1;
      end
   end
   // counts are scrambled outside an offer so a late sample shows up
   assign buf_count_o = buf_valid_o ? cnt_i : ~cnt_i;
   assign buf_size_o  = buf_valid_o ? size_i : ~size_i;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_data_o <= 8'h00;
      end else begin
         mem_data_o <= mem_rd_i ? ({buffer_select_i, mem_addr_i} ^ salt_i) : ~mem_data_o;
      end
   end
endmodule // tx_far_side_model
`default_nettype wire

// *** sim/uart_tx_dma_channel_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_tx_dma_channel_control_tb_top;
   localparam logic [17:0] DEF = {uart_tx_dma_pkg::DEF_IDX, 2'b00};
   localparam logic [17:0] STA = {uart_tx_dma_pkg::STAT_IDX, 2'b00};
   logic        clk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [17:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, seed;
   logic [2:0]  edb_ptr_o, delay;
   logic        buffer_select_o, buf_req_o, buf_valid_i, buf_done_o, wb_valid_o, mem_rd_o;
   logic [6:0]  buf_count_i, buf_size_i, wb_count_o, mem_addr_o, cnt, size;
   logic [7:0]  mem_data_i, tx_data_o, salt;
   logic        tx_valid_o, tx_ready_i, timeout_i, irq_o, avail, stall, ex_sel;
   logic [32:0] rd_q[$], tx_q[$], wb_q[$];
   int          fail_count, checked, irq_n;

   uart_tx_dma_channel_control uut (
      .clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i(4'hF),
      .prdata_o, .pready_o, .pslverr_o, .edb_ptr_o, .buffer_select_o, .buf_req_o, .buf_valid_i,
      .buf_count_i, .buf_size_i, .buf_done_o, .wb_valid_o, .wb_count_o, .mem_rd_o, .mem_addr_o,
      .mem_data_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .timeout_i, .irq_o);
   tx_far_side_model far (
      .clk_i, .srst_i, .buf_req_i(buf_req_o), .buffer_select_i(buffer_select_o), .mem_rd_i(mem_rd_o),
      .mem_addr_i(mem_addr_o), .avail_i(avail), .delay_i(delay), .cnt_i(cnt), .size_i(size),
      .salt_i(salt), .buf_valid_o(buf_valid_i), .buf_count_o(buf_count_i), .buf_size_o(buf_size_i),
      .mem_data_o(mem_data_i));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [17:0] a, input logic [8:0] v);
      @(posedge clk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, 24'h00_0000, v[7:0]};
      if (!wr) rd_q.push_back({v[8], 24'h00_0000, v[7:0]});
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      {psel_i, penable_i} <= 2'b00;
   endtask
   task automatic pulse;
      @(posedge clk_i);
      timeout_i <= 1'b1;
      @(posedge clk_i);
      timeout_i <= 1'b0;
   endtask
   // one buffer; a nonzero go word starts the channel
   task automatic send_buf(input logic [6:0] c, input logic last, input logic [7:0] go);
      int k;
      @(posedge clk_i);
      {cnt, avail} <= {c, 1'b1};
      for (k = 0; k < c; k++) tx_q.push_back({25'h0, {ex_sel, k[6:0]} ^ salt});
      if (go != 8'h00) apb(1'b1, DEF, {1'b0, go});
      do @(posedge clk_i); while (buf_done_o !== 1'b1);
      avail <= !last;
      ex_sel = ~ex_sel;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      seed = xs(seed);
      tx_ready_i <= !stall && (seed[3:2] != 2'b00);
      delay <= {1'b0, seed[9:8]} + 3'h1;
   end
   // ======
   // result watcher
   always @(posedge clk_i) if (srst_i === 1'b0) begin
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
         check({pslverr_o, prdata_o}, rd_q.size() ? rd_q.pop_front() : 'x);
      if (tx_valid_o === 1'b1 && tx_ready_i)
         check(tx_data_o, tx_q.size() ? tx_q.pop_front() : 'x);
      if (wb_valid_o !== 1'b0)
         check(wb_count_o, wb_q.size() ? wb_q.pop_front() : 'x);
      if (irq_o !== 1'b0) irq_n++;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      print_verdict();
   end
   // ======
   // main sequence
   initial begin
      {srst_i, psel_i, penable_i, pwrite_i, timeout_i, avail, stall, tx_ready_i} = 8'h80;
      {paddr_i, pwdata_i, cnt, size, salt, delay} = {18'h0_0000, 32'h0, 7'h00, 7'h04, 8'h00, 3'h1};
      {seed, ex_sel, fail_count, checked, irq_n} = {32'h0001_2EEC, 1'b1, 96'h0};
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      apb(1'b0, DEF, 9'h008);
      apb(1'b0, STA, 9'h000);
      apb(1'b0, 18'h0_0010, 9'h100);
      apb(1'b1, DEF, 9'h017);
      apb(1'b0, DEF, 9'h01F);
      check({edb_ptr_o, buffer_select_o}, 33'hF);
      salt <= seed[7:0];
      send_buf(7'h04, 1'b0, 8'hF3);
      send_buf(7'h04, 1'b0, 8'h00);
      wb_q.push_back(33'h0);
      send_buf(7'h02, 1'b1, 8'h00);
      repeat (6) @(posedge clk_i);
      check(irq_n, 33'h1);
      apb(1'b0, DEF, 9'h06B);
      apb(1'b0, STA, 9'h001);
      apb(1'b1, STA, 9'h0FE);
      apb(1'b0, STA, 9'h001);
      apb(1'b1, STA, 9'h001);
      apb(1'b0, STA, 9'h000);
      send_buf(7'h03, 1'b1, 8'hA3);
      repeat (6) @(posedge clk_i);
      apb(1'b0, DEF, 9'h0BB);
      apb(1'b0, STA, 9'h001);
      apb(1'b1, DEF, 9'h023);
      check(irq_n, 33'h1);
      {cnt, avail} <= {7'h00, 1'b1};
      wb_q.push_back(33'h0);
      apb(1'b1, DEF, 9'h0E3);
      repeat (12) @(posedge clk_i);
      avail <= 1'b0;
      check(irq_n, 33'h2);
      pulse();
      {stall, cnt, avail} <= {1'b1, 7'h06, 1'b1};
      apb(1'b1, DEF, 9'h0E3);
      while (tx_valid_o !== 1'b1) @(posedge clk_i);
      wb_q.push_back(33'h06);
      pulse();
      repeat (8) @(posedge clk_i);
      {stall, avail} <= 2'b00;
      check(irq_n, 33'h3);
      check(tx_q.size() + wb_q.size(), 33'h0);
      print_verdict();
   end
endmodule // uart_tx_dma_channel_control_tb_top
`default_nettype wire
